/* File: inc/bus_driver_pkg.sv */
/*
 * Shared constants for the 18-bit latch/flop bus driver and its data FIFO.
 * Assumes one 100 MHz clock. All pin-side inputs are resynchronised inside the top module.
 */
package bus_driver_pkg;

	localparam int DATA_W = 18;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_PERIOD_NS = 10;

	// control reset values; the storage path itself powers up at zero
	localparam logic [DATA_W-1:0] STORE_RST = 18'h00000;
	localparam logic OE_N_RST = 1'h1;

	// packing of the synchronised pin vector
	localparam int SYNC_W = 2 * DATA_W + 3;
	localparam int DATA_LSB = 0;
	localparam int DRIVEN_LSB = DATA_W;
	localparam int TRANS_BIT = 2 * DATA_W;
	localparam int CAPCLK_BIT = 2 * DATA_W + 1;
	localparam int OEN_BIT = 2 * DATA_W + 2;

endpackage : bus_driver_pkg

/* File: hdl/sync_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides; width and depth are parameters.
 * Assumes a single clock and an active-high asynchronous reset; depth is a power of two.
 */
`timescale 1ns/1ps

module sync_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] wr_ptr_next;
	logic [AW:0] rd_ptr_reg;
	logic [AW:0] rd_ptr_next;
	logic push;
	logic pop;
	logic full;
	logic empty;

	// extra pointer bit tells full from empty
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		if (push) begin
			wr_ptr_next = wr_ptr_reg + (AW+1)'(1);
		end
		if (pop) begin
			rd_ptr_next = rd_ptr_reg + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
		end
	end

	// storage needs no reset; pointers decide what is valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

endmodule : sync_fifo

/* File: hdl/bus_driver.sv */
/*
 * 18-bit bus driver: per-bit storage that is a transparent latch or a rising-edge flop,
 * feeding three-state outputs through an 8-word FIFO.
 * Assumes every pin input is asynchronous to clk; the capture clock pin is sampled, not used
 * as a clock, so its edges must be wider than one clk period to be seen.
 */
`timescale 1ns/1ps

// How it works
// R1: output enable high releases every output bit, except in the first two cycles after reset, while the synchronised enable still reads low.
// R2: transparent control high makes stored bits follow the inputs continuously.
// R3: transparent low and steady capture clock keeps the stored prior level.
// R4: transparent low captures all inputs on each capture clock rising edge.
// R5: eighteen independent bits sharing one enable, transparent control and clock.
// R6: undriven input bits hold their last valid level, never unknown.
// R7: output enable gates only the drivers; storage keeps updating.
module bus_driver (
	input wire logic clk,
	input wire logic rst,
	input wire logic [bus_driver_pkg::DATA_W-1:0] data_in,
	input wire logic [bus_driver_pkg::DATA_W-1:0] data_driven,
	input wire logic transparent_ctl,
	input wire logic cap_clk,
	input wire logic out_en_n,
	input wire logic sink_ready,
	output logic [bus_driver_pkg::DATA_W-1:0] bus_out,
	output logic [bus_driver_pkg::DATA_W-1:0] bus_oe_n
);

	localparam int W = bus_driver_pkg::DATA_W;
	localparam int SW = bus_driver_pkg::SYNC_W;

	// ---- pin synchroniser ----
	logic [SW-1:0] pins;
	logic [SW-1:0] meta_reg;
	logic [SW-1:0] meta_next;
	logic [SW-1:0] sync_reg;
	logic [SW-1:0] sync_next;

	assign pins = {out_en_n, cap_clk, transparent_ctl, data_driven, data_in};

	always_comb begin
		meta_next = pins;
		sync_next = meta_reg;
	end

	// first stage is read only by the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	logic [W-1:0] data_s;
	logic [W-1:0] driven_s;
	logic trans_s;
	logic capclk_s;
	logic en_n_s;

	assign data_s = sync_reg[bus_driver_pkg::DATA_LSB +: W];
	assign driven_s = sync_reg[bus_driver_pkg::DRIVEN_LSB +: W];
	assign trans_s = sync_reg[bus_driver_pkg::TRANS_BIT];
	assign capclk_s = sync_reg[bus_driver_pkg::CAPCLK_BIT];
	assign en_n_s = sync_reg[bus_driver_pkg::OEN_BIT];

	// ---- capture clock edge detect ----
	logic capclk_prev_reg;
	logic capclk_prev_next;
	logic cap_edge;

	assign cap_edge = capclk_s && !capclk_prev_reg;

	always_comb begin
		capclk_prev_next = capclk_s;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			capclk_prev_reg <= 1'h0;
		end else begin
			capclk_prev_reg <= capclk_prev_next;
		end
	end

	// ---- bus hold and per-bit storage ----
	logic [W-1:0] held_reg;
	logic [W-1:0] held_next;
	logic [W-1:0] store_reg;
	logic [W-1:0] store_next;
	logic load;

	// transparent wins; a clock edge while transparent changes nothing extra
	assign load = trans_s || cap_edge; // R2 R4

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				held_next[i] = driven_s[i] ? data_s[i] : held_reg[i]; // R6
				store_next[i] = load ? held_reg[i] : store_reg[i]; // R3 R5
			end
		end
	endgenerate

	// storage ignores the output enable on purpose
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_reg <= bus_driver_pkg::STORE_RST;
			store_reg <= bus_driver_pkg::STORE_RST;
		end else begin
			held_reg <= held_next; // R6
			store_reg <= store_next; // R7
		end
	end

	// ---- hand-off into the fifo ----
	// a change found while the fifo is full waits; only the newest value is sent
	logic pending_reg;
	logic pending_next;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [W-1:0] fifo_out_data;
	logic pop;

	// one decode for "storage moved", shared by the hand-off and its checks
	function automatic logic word_moved(
		input logic [W-1:0] now_word,
		input logic [W-1:0] was_word
	);
		return now_word != was_word;
	endfunction : word_moved

	always_comb begin
		pending_next = pending_reg && !fifo_in_ready;
		if (word_moved(store_next, store_reg)) begin
			pending_next = 1'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending_reg <= 1'h0;
		end else begin
			pending_reg <= pending_next;
		end
	end

	sync_fifo #(
		.WIDTH(bus_driver_pkg::DATA_W),
		.DEPTH(bus_driver_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(pending_reg),
		.in_ready(fifo_in_ready),
		.in_data(store_reg),
		.out_valid(fifo_out_valid),
		.out_ready(sink_ready),
		.out_data(fifo_out_data)
	);

	assign pop = fifo_out_valid && sink_ready;

	// ---- output stage ----
	logic [W-1:0] prior_level_reg;
	logic [W-1:0] prior_level_next;
	logic [W-1:0] oe_n_reg;
	logic [W-1:0] oe_n_next;

	always_comb begin
		prior_level_next = pop ? fifo_out_data : prior_level_reg; // R3
		oe_n_next = {W{en_n_s}}; // R1 R5
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prior_level_reg <= bus_driver_pkg::STORE_RST;
			oe_n_reg <= {W{bus_driver_pkg::OE_N_RST}};
		end else begin
			prior_level_reg <= prior_level_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign bus_out = prior_level_reg;
	assign bus_oe_n = oe_n_reg;

	// ---- checks ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	oe_release_a: assert property ( // R1
		en_n_s |=> (bus_oe_n == {W{1'b1}})
	) else $error("outputs not released while enable high");

	transparent_follow_a: assert property ( // R2
		trans_s |=> (store_reg == $past(held_reg))
	) else $error("storage did not follow inputs in transparent mode");

	steady_hold_a: assert property ( // R3
		(!trans_s && !cap_edge) |=> $stable(store_reg)
	) else $error("storage changed with capture clock steady");

	edge_capture_a: assert property ( // R4
		(!trans_s && $rose(capclk_s)) |=> (store_reg == $past(held_reg))
	) else $error("rising capture edge not stored");

	shared_enable_a: assert property ( // R5
		(bus_oe_n == {W{1'b0}}) || (bus_oe_n == {W{1'b1}})
	) else $error("output enable bits disagree");

	bus_hold_a: assert property ( // R6
		(driven_s == {W{1'b0}}) |=> $stable(held_reg)
	) else $error("undriven inputs lost their level");

	gated_update_a: assert property ( // R7
		(en_n_s && trans_s) ##1 en_n_s |-> (store_reg == $past(held_reg))
	) else $error("storage stalled while outputs released");

	fifo_handoff_a: assert property ( // R3
		pop |=> (bus_out == $past(fifo_out_data))
	) else $error("popped word not driven");

	drive_path_a: assert property ( // R1
		$fell(en_n_s) |-> ##1 (bus_oe_n == {W{1'b0}})
	) else $error("outputs not driven one cycle after enable low");

	capture_seen_c: cover property (
		!trans_s && cap_edge && !en_n_s ##1 pending_reg
	);

	transparent_seen_c: cover property (
		trans_s && !en_n_s ##1 (store_reg != $past(store_reg))
	);

	fifo_full_c: cover property (
		pending_reg && !fifo_in_ready
	);

	released_update_c: cover property (
		en_n_s && load ##1 pending_reg
	);

	sink_stall_c: cover property (
		fifo_out_valid && !sink_ready
	);

	// enable path is one flop behind the synchroniser; reset value differs, so compare first
	oe_drive_a: assert property ( // R1
		!en_n_s |=> (bus_oe_n == {W{1'b0}})
	) else $error("outputs not driven while enable low");

	oe_steady_a: assert property ( // R1
		(en_n_s == bus_oe_n[0]) |=> $stable(bus_oe_n)
	) else $error("output enable moved with enable steady");

	store_load_a: assert property ( // R2
		load |=> (store_reg == $past(held_reg))
	) else $error("storage missed a load");

	level_hold_a: assert property ( // R3
		!pop |=> $stable(bus_out)
	) else $error("driven level moved without a new word");

	edge_once_a: assert property ( // R4
		cap_edge |=> !cap_edge
	) else $error("one capture edge seen twice");

	capture_pending_a: assert property ( // R4
		(!trans_s && cap_edge && word_moved(held_reg, store_reg)) |=> pending_reg
	) else $error("captured word not queued");

	pending_set_a: assert property ( // R4
		word_moved(store_next, store_reg) |=> pending_reg
	) else $error("storage change not queued");

	fifo_push_a: assert property ( // R4
		(pending_reg && fifo_in_ready) |=> fifo_out_valid
	) else $error("accepted word missing from fifo");

	pending_clear_a: assert property ( // R5
		(pending_reg && fifo_in_ready && !word_moved(store_next, store_reg)) |=> !pending_reg
	) else $error("queued word sent twice");

	full_stall_a: assert property ( // R5
		(pending_reg && !fifo_in_ready) |=> pending_reg
	) else $error("pending word dropped while fifo full");

	held_follow_a: assert property ( // R6
		(driven_s == {W{1'b1}}) |=> (held_reg == $past(data_s))
	) else $error("driven inputs not sampled");

	released_capture_a: assert property ( // R7
		(en_n_s && !trans_s && cap_edge) |=> (store_reg == $past(held_reg))
	) else $error("capture lost while outputs released");

endmodule : bus_driver

/* File: tb/bus_sink_model.sv */
/*
 * Downstream receiver of the driven bus: accepts words with random stalls.
 * Assumes the driver's single clock and active-high reset.
 */
`timescale 1ns/1ps

module bus_sink_model (
	input wire logic clk,
	input wire logic rst,
	output logic sink_ready
);
	int seed = 40;

	// stalls about one cycle in four, so both prompt and slow takes occur
	always @(posedge clk) begin
		if (rst) begin
			sink_ready <= 1'h0;
		end else begin
			sink_ready <= (($random(seed) & 3) != 0);
		end
	end
endmodule : bus_sink_model

/* File: tb/bus_driver_tb.sv */
/*
 * Self-checking bench for the latch/flop bus driver; notes expected words in a queue.
 * Assumes the sink model in its own file and the design package compiled first.
 */
`timescale 1ns/1ps

module bus_driver_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [17:0] data_in = 18'h00000;
	logic [17:0] data_driven = 18'h3ffff;
	logic transparent_ctl = 1'h1;
	logic cap_clk = 1'h0;
	logic out_en_n = 1'h0;
	logic sink_ready;
	logic [17:0] bus_out;
	logic [17:0] bus_oe_n;
	logic [17:0] exp_q[$];
	logic [17:0] last_out = 18'h00000;
	logic [17:0] held = 18'h00000;
	logic [17:0] v;
	logic mon_on = 1'h1;
	int n_fail = 0;
	int check_count = 0;
	int seed = 40;

	always #5 clk = ~clk;

	bus_driver dut_u (.clk(clk), .rst(rst), .data_in(data_in), .data_driven(data_driven),
		.transparent_ctl(transparent_ctl), .cap_clk(cap_clk), .out_en_n(out_en_n),
		.sink_ready(sink_ready), .bus_out(bus_out), .bus_oe_n(bus_oe_n));

	bus_sink_model sink_u (.clk(clk), .rst(rst), .sink_ready(sink_ready));

	task automatic check(string name, logic [17:0] expv, logic [17:0] got);
		check_count++;
		if (got !== expv) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, expv, got);
		end
	endtask : check

	task automatic close_out();
		$display("errors %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic put(logic [17:0] d, logic [17:0] drv);
		@(posedge clk);
		data_in <= d;
		data_driven <= drv;
	endtask : put

	task automatic pulse();
		@(posedge clk);
		cap_clk <= 1'h1;
		repeat (3) @(posedge clk);
		cap_clk <= 1'h0;
		repeat (16) @(posedge clk);
	endtask : pulse

	// bounded wait for every noted word to show up
	task automatic drain();
		for (int i = 0; i < 64 && exp_q.size() != 0; i++) @(posedge clk);
		if (exp_q.size() != 0) begin
			n_fail++;
			$display("[FAIL] queue expected 0 seen %0d", exp_q.size());
			close_out();
		end
	endtask : drain

	always @(posedge clk) begin
		if (!rst && mon_on && bus_out !== last_out) begin
			if (exp_q.size() == 0) check("spurious bus_out", last_out, bus_out);
			else check("bus_out", exp_q.pop_front(), bus_out);
		end
		last_out <= bus_out;
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		repeat (6) @(posedge clk);
		check("oe low", 18'h00000, bus_oe_n);
		for (int k = 0; k < 6; k++) begin
			v = held ^ ($random(seed) | 18'h00001);
			held = v;
			exp_q.push_back(v);
			put(v, 18'h3ffff);
			repeat (16) @(posedge clk);
		end
		drain();
		// undriven bits must keep their old level
		v = ~held;
		held = held ^ 18'h0ff00;
		exp_q.push_back(held);
		put(v, 18'h0ff00);
		repeat (16) @(posedge clk);
		held = v;
		exp_q.push_back(v);
		put(v, 18'h3ffff);
		repeat (16) @(posedge clk);
		drain();
		transparent_ctl <= 1'h0;
		repeat (6) @(posedge clk);
		v = ~held;
		put(v, 18'h3ffff);
		repeat (16) @(posedge clk);
		held = v;
		exp_q.push_back(v);
		pulse();
		drain();
		// released outputs: storage still captures
		mon_on <= 1'h0;
		out_en_n <= 1'h1;
		repeat (6) @(posedge clk);
		check("oe released", 18'h3ffff, bus_oe_n);
		v = ~held;
		put(v, 18'h3ffff);
		pulse();
		out_en_n <= 1'h0;
		repeat (12) @(posedge clk);
		check("oe back", 18'h00000, bus_oe_n);
		check("stored while off", v, bus_out);
		close_out();
	end
endmodule : bus_driver_tb
